// ==== scif_init_fsm.sv ====
// Core initialization and power-state machine of one buffer_device.
// Assumes lane event inputs are already synchronous to clock.
//
// Behaviour
// - Disable keeps all lanes in electrical idle.
// - Training does bit then frame alignment.
// - Testing checks each lane on its own.
// - Polling reports device capabilities to host.
// - Active state carries frames both ways.
// - Recalibrate idles channel briefly then resumes.
// - Optional low-power standby state supported.
// - Transitions need minimum count of southbound lanes.
// - Lanes initialize independently; failed lanes dropped.
// - Electrical idle acted on only across lanes.
// - Idle entry detected within 60 ns.
// - Idle exit detected within 30 ns.
// - Deskew tolerates 6 UI lane skew.
// - Init establishes southbound broadcast, northbound merge timing.
`timescale 1ns/100ps
`default_nettype none
module scif_init_fsm
  import scif_pkg::*;
#(
  parameter int            LANES       = scif_pkg::NUM_LANES,
  parameter int            TIMEOUT_CYC = scif_pkg::STEP_TIMEOUT,
  parameter bit            STANDBY_EN  = 1'b1,
  parameter logic [7:0]    CAPS        = 8'h5A
)
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire scif_pkg::scif_lane_ev_s lane_ev,
  input  wire logic [3:0]            cfg_width,
  output logic [LANES-1:0]           lane_tx_idle,
  output logic                       align_en,
  output logic                       deskew_en,
  output logic [LANES-1:0]           lane_test_en,
  output logic                       caps_valid,
  output logic [7:0]                 caps,
  output logic [3:0]                 active_width,
  output logic                       frames_en,
  output logic                       recal_en,
  output logic                       standby,
  output logic [LANES-1:0]           lane_good,
  output logic                       init_fault,
  output scif_pkg::scif_state_e      state
);
  import scif_pkg::*;

  // Narrowed copies of the timing constants for the idle filter and step timer.
  localparam logic [11:0] TMO_MAX = 12'(TIMEOUT_CYC);
  localparam logic [2:0]  EI_ENTRY_N = 3'(EI_ENTRY_CYC);
  localparam logic [2:0]  EI_EXIT_N = 3'(EI_EXIT_CYC);

  scif_reg_s r_ff;
  scif_reg_s nxt_r;

  // Counts lanes that are set and still usable.
  function automatic logic quorum(input logic [LANES-1:0] v, input logic [LANES-1:0] m,
                                  input int need);
    int n;
    n = 0;
    for (int i = 0; i < LANES; i++)
    begin
      if (v[i] && m[i])
        n++;
    end
    return n >= need;
  endfunction

  logic ei_any;
  logic step_ok;
  logic step_fail;

  always_comb
  begin
    nxt_r    = r_ff;
    ei_any   = quorum(lane_ev.ei, r_ff.lane_good, EI_MIN_LANES);
    step_ok  = 1'b0;
    step_fail = 1'b0;
    // Idle filter: entry after EI_ENTRY_N cycles, exit after EI_EXIT_N cycles.
    if (ei_any != r_ff.ei_q)
    begin
      nxt_r.ei_cnt = r_ff.ei_cnt + 3'h1;
      if ((ei_any && r_ff.ei_cnt + 3'h1 >= EI_ENTRY_N) ||
          (!ei_any && r_ff.ei_cnt + 3'h1 >= EI_EXIT_N))
      begin
        nxt_r.ei_q   = ei_any;
        nxt_r.ei_cnt = 3'h0;
      end
    end
    else
      nxt_r.ei_cnt = 3'h0;

    // The step timer runs in every state but Disable, Active and Standby, so a stuck
    // init or Recalibrate step cannot leave the device hanging outside Disable.
    if (r_ff.state != ST_DISABLE && r_ff.state != ST_ACTIVE &&
        r_ff.state != ST_STANDBY)
    begin
      nxt_r.tmo = r_ff.tmo + 12'h001;
      if (r_ff.tmo >= TMO_MAX - 12'h001)
        step_fail = 1'b1;
    end
    else
      nxt_r.tmo = TMO_RST;

    case (r_ff.state)
      ST_DISABLE:
      begin
        // Every lane gets a fresh chance at each new init sequence.
        nxt_r.lane_good = '1;
        nxt_r.width = WIDTH_RST;
        if (!r_ff.ei_q)
        begin
          nxt_r.state = ST_TRAINING;
          nxt_r.fault = 1'b0;
        end
      end
      ST_TRAINING:
      begin
        // Lanes that never lock are dropped, the rest carry on.
        // Every lane may count here, since lane_good is only settled by this step.
        step_ok = quorum(lane_ev.frame_lock & lane_ev.bit_lock, '1,
                         MIN_LANES);
        if (step_ok)
        begin
          nxt_r.lane_good = lane_ev.frame_lock & lane_ev.bit_lock;
          nxt_r.state = ST_TESTING;
        end
      end
      ST_TESTING:
      begin
        step_ok = quorum(lane_ev.test_pass, r_ff.lane_good, MIN_LANES);
        if (step_ok)
        begin
          nxt_r.lane_good = r_ff.lane_good & lane_ev.test_pass;
          nxt_r.state = ST_POLLING;
        end
      end
      ST_POLLING:
        if (quorum(lane_ev.cfg_seen, r_ff.lane_good, MIN_LANES))
          nxt_r.state = ST_CONFIG;
      ST_CONFIG:
      begin
        // Width is taken every cycle; the value seen as cfg_seen drops sticks.
        nxt_r.width = cfg_width;
        if (!quorum(lane_ev.cfg_seen, r_ff.lane_good, MIN_LANES))
          nxt_r.state = ST_ACTIVE;
      end
      // Recalibrate wins over standby, and both win over idle entry.
      ST_ACTIVE:
        if (quorum(lane_ev.recal_req, r_ff.lane_good, MIN_LANES))
          nxt_r.state = ST_RECAL;
        else if (STANDBY_EN && quorum(lane_ev.stby_req, r_ff.lane_good, MIN_LANES))
          nxt_r.state = ST_STANDBY;
        else if (r_ff.ei_q)
          nxt_r.state = ST_DISABLE;
      ST_RECAL:
        if (!quorum(lane_ev.recal_req, r_ff.lane_good, MIN_LANES))
          nxt_r.state = ST_ACTIVE;
      // Standby ends only once the lanes have left idle again.
      ST_STANDBY:
        if (!r_ff.ei_q && !quorum(lane_ev.stby_req, r_ff.lane_good, MIN_LANES))
          nxt_r.state = ST_ACTIVE;
      default:
        nxt_r.state = ST_DISABLE;
    endcase

    // A state left in this cycle counts as progress, so the timer restarts for
    // the next step; only a step that makes no progress times out. Leaving
    // Recalibrate on time-out is not an init failure, so no fault is flagged.
    if (nxt_r.state != r_ff.state)
      nxt_r.tmo = TMO_RST;
    else if (step_fail)
    begin
      nxt_r.state = ST_DISABLE;
      nxt_r.tmo   = TMO_RST;
      nxt_r.fault = (r_ff.state != ST_RECAL);
    end
  end

  // The idle filter starts out idle, so the lanes must show activity first.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      r_ff.state     <= ST_DISABLE;
      r_ff.tmo       <= TMO_RST;
      r_ff.lane_good <= '1;
      r_ff.width     <= WIDTH_RST;
      r_ff.ei_cnt    <= 3'h0;
      r_ff.ei_q      <= 1'b1;
      r_ff.fault     <= 1'b0;
    end
    else
      r_ff <= nxt_r;
  end

  // Outputs decode the state register, so they change in step with it.
  always_comb
  begin
    state        = r_ff.state;
    lane_good    = r_ff.lane_good;
    init_fault   = r_ff.fault;
    active_width = r_ff.width;
    caps         = CAPS;
    lane_tx_idle = (r_ff.state == ST_DISABLE || r_ff.state == ST_RECAL ||
                    r_ff.state == ST_STANDBY) ? '1 : '0;
    align_en     = (r_ff.state == ST_TRAINING);
    deskew_en    = (r_ff.state == ST_TRAINING);
    lane_test_en = (r_ff.state == ST_TESTING) ? r_ff.lane_good : '0;
    caps_valid   = (r_ff.state == ST_POLLING);
    frames_en    = (r_ff.state == ST_ACTIVE);
    recal_en     = (r_ff.state == ST_RECAL);
    standby      = (r_ff.state == ST_STANDBY);
  end
endmodule
`default_nettype wire

// ==== scif_pkg.sv ====
// Package for the serial channel initialization state machine.
// Assumes one 40 MHz clock; lane events arrive as per-lane flags.
package scif_pkg;
  localparam int NUM_LANES   = 10;
  localparam int CLK_PS      = 25000;
  localparam int EI_ENTRY_NS = 60;
  localparam int EI_EXIT_NS  = 30;
  // Longest times round down, never below one cycle.
  localparam int EI_ENTRY_CYC = (EI_ENTRY_NS * 1000 / CLK_PS) < 1 ? 1 :
                                (EI_ENTRY_NS * 1000 / CLK_PS);
  localparam int EI_EXIT_CYC  = (EI_EXIT_NS * 1000 / CLK_PS) < 1 ? 1 :
                                (EI_EXIT_NS * 1000 / CLK_PS);
  localparam int DESKEW_UI    = 6;
  localparam int MIN_LANES    = 7;
  localparam int EI_MIN_LANES = 2;
  localparam int STEP_TIMEOUT = 4000;
  localparam logic [11:0] TMO_RST = 12'h000;
  localparam logic [3:0]  WIDTH_RST = 4'h0;

  typedef enum logic [3:0] {
    ST_DISABLE, ST_TRAINING, ST_TESTING, ST_POLLING, ST_CONFIG,
    ST_ACTIVE, ST_RECAL, ST_STANDBY
  } scif_state_e;

  // Per-lane events reported by the lane receivers.
  typedef struct packed {
    logic [NUM_LANES-1:0] ei;         // electrical_idle seen on lane
    logic [NUM_LANES-1:0] bit_lock;   // bit alignment done
    logic [NUM_LANES-1:0] frame_lock; // frame alignment done
    logic [NUM_LANES-1:0] test_pass;  // per-lane test pattern passed
    logic [NUM_LANES-1:0] poll_seen;  // polling pattern seen
    logic [NUM_LANES-1:0] cfg_seen;   // config pattern seen
    logic [NUM_LANES-1:0] recal_req;  // recalibrate request seen
    logic [NUM_LANES-1:0] stby_req;   // standby request seen
  } scif_lane_ev_s;

  typedef struct packed {
    scif_state_e          state;
    logic [11:0]          tmo;
    logic [NUM_LANES-1:0] lane_good;
    logic [3:0]           width;
    logic [2:0]           ei_cnt;
    logic                 ei_q;
    logic                 fault;
  } scif_reg_s;
endpackage

// ==== scif_init_fsm_chk.sv ====
// Checker on the ports of the init state machine.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module scif_init_fsm_chk
  import scif_pkg::*;
#(parameter int LANES = NUM_LANES)
(
  input wire logic                   clock,
  input wire logic                   sys_rst,
  input wire scif_pkg::scif_lane_ev_s lane_ev,
  input wire logic [3:0]             cfg_width,
  input wire logic [LANES-1:0]       lane_tx_idle,
  input wire logic                   align_en,
  input wire logic                   deskew_en,
  input wire logic [LANES-1:0]       lane_test_en,
  input wire logic [3:0]             active_width,
  input wire logic                   frames_en,
  input wire logic                   recal_en,
  input wire logic [LANES-1:0]       lane_good,
  input wire scif_pkg::scif_state_e  state
);
  import scif_pkg::*;
  logic [LANES-1:0] lock;
  logic [LANES-1:0] idl;
  assign lock = lane_ev.bit_lock & lane_ev.frame_lock;
  assign idl = lane_ev.ei & lane_good;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_tr_te; state == ST_TESTING && $past(state) == ST_TRAINING; endsequence
  sequence s_cf_ac; state == ST_ACTIVE && $past(state) == ST_CONFIG; endsequence
  sequence s_ac_di; state == ST_DISABLE && $past(state) == ST_ACTIVE; endsequence
  chk_disable_idle: assert property (
    state == ST_DISABLE |-> &lane_tx_idle && !frames_en)
    else $error("lanes not idle in disable");
  chk_train_align: assert property (state == ST_TRAINING |-> align_en && deskew_en)
    else $error("alignment off in training");
  chk_test_lanes: assert property (state == ST_TESTING |-> lane_test_en == lane_good)
    else $error("lane test enables wrong");
  chk_lock_quorum: assert property (s_tr_te |-> $countones($past(lock)) >= MIN_LANES)
    else $error("training left without quorum");
  chk_cfg_width: assert property (s_cf_ac |-> active_width == $past(cfg_width))
    else $error("width not adopted");
  chk_active_frames: assert property (state == ST_ACTIVE |-> frames_en && !recal_en)
    else $error("frames off in active");
  chk_recal_idle: assert property (state == ST_RECAL |-> recal_en && &lane_tx_idle)
    else $error("recalibrate not idle");
  chk_idle_quorum: assert property (
    s_ac_di |-> $countones($past(idl, 2)) >= EI_MIN_LANES)
    else $error("idle acted on too few lanes");
endmodule

bind scif_init_fsm scif_init_fsm_chk #(.LANES(LANES)) chk_u (.clock, .sys_rst, .lane_ev,
  .cfg_width, .lane_tx_idle, .align_en, .deskew_en, .lane_test_en, .active_width,
  .frames_en, .recal_en, .lane_good, .state);
`default_nettype wire

// ==== scif_host_model.sv ====
// Host model: raises the chosen event flags on the chosen southbound lanes.
// Assumes the bench picks flags and lanes at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module scif_host_model
  import scif_pkg::*;
(
  input  wire logic [7:0]           cmd,
  input  wire logic [NUM_LANES-1:0] mask,
  output scif_pkg::scif_lane_ev_s   lane_ev
);
  import scif_pkg::*;
  always_comb
  begin
    for (int k = 0; k < 8; k++)
      lane_ev[k*NUM_LANES +: NUM_LANES] = cmd[k] ? mask : '0;
  end
endmodule
`default_nettype wire

// ==== scif_init_fsm_bench.sv ====
// Self-checking bench for the init state machine.
// Assumes the host model drives lane events; step timeout is shortened.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got %h want %h", $time, a, e); end end
module scif_init_fsm_bench;
  import scif_pkg::*;
  localparam int TMO = 50;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] cmd = 8'h00;
  logic [3:0] cfg_width = 4'h0;
  logic [9:0] mask = '0;
  logic [9:0] good;
  logic [9:0] lane_tx_idle, lane_test_en, lane_good;
  logic align_en, deskew_en, caps_valid, frames_en, recal_en, standby, init_fault;
  logic [7:0] caps;
  logic [3:0] active_width;
  scif_lane_ev_s lane_ev;
  scif_state_e state;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 67680;
  always #12.5 clock = ~clock;
  scif_host_model host_u (.cmd, .mask, .lane_ev);
  scif_init_fsm #(.TIMEOUT_CYC(TMO)) dut_u (.clock, .sys_rst, .lane_ev, .cfg_width,
    .lane_tx_idle, .align_en, .deskew_en, .lane_test_en, .caps_valid, .caps, .active_width,
    .frames_en, .recal_en, .standby, .lane_good, .init_fault, .state);
  function automatic logic [9:0] drop_lane();
    return 10'h001 << ($unsigned($random(seed)) % 10);
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input logic [7:0] c, input logic [9:0] m, input scif_state_e e, input int n);
    @(negedge clock);
    cmd = c;
    mask = m;
    for (int i = 0; i < n && state !== e; i++)
      @(negedge clock);
    `CHK(state, e)
    $display("test toward %s done", e.name());
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    `CHK({lane_tx_idle, active_width}, 14'h3FF0)
    step(8'h00, '0, ST_TRAINING, 4);
    `CHK({align_en, deskew_en}, 2'h3)
    step(8'h60, 10'h03F, ST_TRAINING, 1);
    repeat (4) @(negedge clock);
    `CHK(state, ST_TRAINING)
    good = ~(drop_lane() | drop_lane());
    step(8'h60, good, ST_TESTING, 4);
    `CHK(lane_good, good)
    `CHK(lane_test_en, good)
    step(8'h10, good, ST_POLLING, 4);
    `CHK({caps_valid, caps}, 9'h15A)
    cfg_width = 4'($random(seed));
    step(8'h04, good, ST_CONFIG, 4);
    step(8'h00, good, ST_ACTIVE, 4);
    `CHK({frames_en, active_width}, {1'b1, cfg_width})
    step(8'h02, good, ST_RECAL, 4);
    `CHK({recal_en, lane_tx_idle}, 11'h7FF)
    step(8'h00, good, ST_ACTIVE, 4);
    step(8'h01, good, ST_STANDBY, 4);
    `CHK({standby, lane_tx_idle}, 11'h7FF)
    step(8'h00, good, ST_ACTIVE, 4);
    step(8'h80, good & (~good + 10'h001), ST_ACTIVE, 1);
    repeat (4) @(negedge clock);
    `CHK(state, ST_ACTIVE)
    step(8'h80, good, ST_DISABLE, EI_ENTRY_CYC + 1);
    // Width is cleared one edge after Disable is entered.
    @(negedge clock);
    `CHK({frames_en, active_width}, 5'h00)
    step(8'h00, '0, ST_TRAINING, EI_EXIT_CYC + 1);
    step(8'h00, '0, ST_DISABLE, TMO + 4);
    `CHK(init_fault, 1'b1)
    stop_test();
  end
  initial
  begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
